// [slx_exec.sv]
// execution unit for skip, or, literal-load and store operations
// Function
// RULE1: destination bit picks accumulator or file register
// RULE2: decrement-skip subtracts one, skips on zero
// RULE3: increment-skip adds one, skips on zero
// RULE4: or-literal into accumulator, updates zero flag
// RULE5: load literal into accumulator, flags untouched
// RULE6: or register to destination, updates zero
// RULE7: store accumulator to 7-bit register address
// RULE8: zero flag set on zero result only
`timescale 1ns/1ps
`default_nettype none
module slx_exec (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cyc_en,
    input  wire logic [2:0] op,
    input  wire logic       dest,
    input  wire logic [6:0] faddr,
    input  wire logic [7:0] literal,
    input  wire logic [7:0] reg_rdata,
    output logic      [6:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    output logic      [7:0] acc,
    output logic            zero_flag,
    output logic            skip_active
);
    slx_pkg::slx_state_t state_r, state_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic       zf_r, zf_nxt;
    logic [7:0] alu_res;
    logic       alu_zero;

    // opcode classes; the skip and file classes each feed more than one place, so one definition keeps
    // the write strobe, the accumulator path and the skip state machine from drifting apart
    function automatic logic op_is_skip(input logic [2:0] code);
        return (code == slx_pkg::SLX_OP_DEC_SKZ) | (code == slx_pkg::SLX_OP_INC_SKZ);
    endfunction

    // skip ops plus or-register: the ops that read a file register and honour dest
    function automatic logic op_is_file(input logic [2:0] code);
        return op_is_skip(code) | (code == slx_pkg::SLX_OP_OR_REG);
    endfunction

    // the two or ops are the only ones that touch the zero flag
    function automatic logic op_sets_zero(input logic [2:0] code);
        return (code == slx_pkg::SLX_OP_OR_LIT) | (code == slx_pkg::SLX_OP_OR_REG);
    endfunction

    // literal ops always land in the accumulator
    function automatic logic op_is_literal(input logic [2:0] code);
        return (code == slx_pkg::SLX_OP_OR_LIT) | (code == slx_pkg::SLX_OP_LD_LIT);
    endfunction

    // named decode wires; dest is honoured only by the file-register ops,
    // the store ignores it and always writes
    wire        run       = (state_r == slx_pkg::SLX_ST_RUN);
    wire        is_skipop = op_is_skip(op);
    wire        is_fileop = op_is_file(op);
    wire        is_litop  = op_is_literal(op);
    wire        is_zeroop = op_sets_zero(op);
    wire        is_store  = (op == slx_pkg::SLX_OP_ST_ACC);
    wire        dest_reg  = (dest == slx_pkg::DEST_REG);
    wire        do_exec   = cyc_en & run;

    slx_alu u_alu (
        .op      (op),
        .acc     (acc_r),
        .reg_val (reg_rdata),
        .literal (literal),
        .result  (alu_res),
        .is_zero (alu_zero)
    );

    // file-op results go to register when dest set, store always writes
    assign reg_addr  = faddr; // RULE7
    assign reg_we    = do_exec & ((is_fileop & dest_reg) | is_store); // RULE1
    assign reg_wdata = is_store ? acc_r : alu_res; // RULE7

    // accumulator takes literal ops and file ops aimed at it;
    // a store or a register-bound result leaves it alone
    assign acc_nxt = (do_exec & (is_litop | (is_fileop & ~dest_reg)))
                     ? alu_res : acc_r; // RULE1 RULE4 RULE5

    // only the two or operations touch zero; skips, loads, stores leave it,
    // so a skip loop can test a counter without losing an earlier zero result
    assign zf_nxt = (do_exec & is_zeroop) ? alu_zero : zf_r; // RULE4 RULE6 RULE8

    // a zero skip result turns the following slot into an idle one
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            slx_pkg::SLX_ST_RUN: begin
                if (do_exec & is_skipop & alu_zero) begin
                    state_nxt = slx_pkg::SLX_ST_IDLE; // RULE2 RULE3
                end
            end
            slx_pkg::SLX_ST_IDLE: begin
                if (cyc_en) begin
                    state_nxt = slx_pkg::SLX_ST_RUN;
                end
            end
            default: state_nxt = slx_pkg::SLX_ST_RUN;
        endcase
    end

    // short register stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= slx_pkg::SLX_ST_RUN;
            acc_r   <= slx_pkg::ACC_RESET;
            zf_r    <= slx_pkg::ZF_RESET;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            zf_r    <= zf_nxt;
        end
    end

    assign acc         = acc_r;
    assign zero_flag   = zf_r;
    assign skip_active = ~run;

    // checks; all are sampled on the clock and silenced while reset is held
    // the skip path is built from its steps
    sequence s_zero_skip;
        do_exec && is_skipop && alu_zero;
    endsequence

    sequence s_slot_swallowed;
        skip_active && cyc_en && !reg_we;
    endsequence

    sequence s_slot_missed;
        skip_active && !cyc_en;
    endsequence

    a_skip_enters_idle: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        s_zero_skip |=> skip_active)
        else $error("zero skip result did not idle next slot");

    a_skip_nonzero_runs: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        do_exec && is_skipop && !alu_zero |=> !skip_active)
        else $error("nonzero skip result idled");

    a_idle_blocks_write: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        skip_active |-> !reg_we)
        else $error("write during idle slot");

    a_skip_two_slots: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        s_zero_skip ##1 s_slot_swallowed |=> !skip_active && $stable(acc) && $stable(zero_flag))
        else $error("skip did not last exactly one extra slot");

    // the slot after a zero skip
    a_idle_waits_slot: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        s_slot_missed |=> skip_active)
        else $error("idle slot ended without an instruction slot");

    a_idle_keeps_state: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        skip_active |=> $stable(acc) && $stable(zero_flag))
        else $error("idle slot changed accumulator or zero flag");

    // results of the two skip operations, seen on the write data path
    a_dec_result: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        do_exec && op == slx_pkg::SLX_OP_DEC_SKZ
        |-> reg_wdata == reg_rdata - slx_pkg::ONE_BYTE)
        else $error("decrement result wrong");

    a_inc_result: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        do_exec && op == slx_pkg::SLX_OP_INC_SKZ
        |-> reg_wdata == reg_rdata + slx_pkg::ONE_BYTE)
        else $error("increment result wrong");

    a_skip_keeps_zf: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        do_exec && (is_skipop || op == slx_pkg::SLX_OP_LD_LIT || is_store)
        |=> $stable(zero_flag))
        else $error("zero flag changed by non-flag op");

    // destination routing
    a_dest_reg_keeps: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        do_exec && is_fileop && dest == slx_pkg::DEST_REG |-> reg_we ##1 $stable(acc))
        else $error("register destination misrouted");

    a_acc_dest_routes: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        do_exec && is_fileop && !dest_reg |-> !reg_we ##1 acc == $past(reg_wdata))
        else $error("accumulator destination misrouted");

    // literal and or operations
    a_or_lit_result: assert property (@(posedge clk) disable iff (!rstn) // RULE4
        do_exec && op == slx_pkg::SLX_OP_OR_LIT |=> acc == ($past(acc) | $past(literal)))
        else $error("or literal result wrong");

    a_or_lit_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        do_exec && op == slx_pkg::SLX_OP_OR_LIT |=> zero_flag == (acc == slx_pkg::ZERO_BYTE))
        else $error("or literal zero flag wrong");

    a_ld_lit_result: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        do_exec && op == slx_pkg::SLX_OP_LD_LIT |=> acc == $past(literal))
        else $error("load literal wrong");

    a_or_reg_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        do_exec && op == slx_pkg::SLX_OP_OR_REG
        |=> zero_flag == (($past(acc) | $past(reg_rdata)) == slx_pkg::ZERO_BYTE))
        else $error("or register zero flag wrong");

    a_or_reg_acc: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        do_exec && op == slx_pkg::SLX_OP_OR_REG && !dest_reg |=> acc == ($past(acc) | $past(reg_rdata)))
        else $error("or register accumulator result wrong");

    a_or_reg_file: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        do_exec && op == slx_pkg::SLX_OP_OR_REG && dest_reg |-> reg_wdata == (acc | reg_rdata))
        else $error("or register write data wrong");

    // store and unexecuted slots
    a_store_write: assert property (@(posedge clk) disable iff (!rstn) // RULE7
        do_exec && op == slx_pkg::SLX_OP_ST_ACC |-> reg_we && reg_wdata == acc)
        else $error("store did not write accumulator");

    a_store_keeps_acc: assert property (@(posedge clk) disable iff (!rstn) // RULE7
        do_exec && is_store |=> $stable(acc) && $stable(zero_flag))
        else $error("store changed accumulator or zero flag");

    a_no_exec_holds: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        !do_exec |=> $stable(acc) && $stable(zero_flag))
        else $error("state changed without an executed slot");
endmodule
`default_nettype wire

// [slx_pkg.sv]
// shared constants for the skip and logic operation executor
package slx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OP_W   = 3;
    // operation selector codes presented by the decoder
    typedef enum logic [2:0] {
        SLX_OP_IDLE    = 3'h0,
        SLX_OP_DEC_SKZ = 3'h1,
        SLX_OP_INC_SKZ = 3'h2,
        SLX_OP_OR_LIT  = 3'h3,
        SLX_OP_LD_LIT  = 3'h4,
        SLX_OP_OR_REG  = 3'h5,
        SLX_OP_ST_ACC  = 3'h6
    } slx_op_t;
    // destination bit meaning
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_REG = 1'h1;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE  = 8'h01;
    localparam logic       ZF_RESET  = 1'h0;
    // executor states, gray coded
    typedef enum logic [1:0] {
        SLX_ST_RUN  = 2'h0,
        SLX_ST_IDLE = 2'h1
    } slx_state_t;
endpackage

// [slx_alu.sv]
// combinational datapath for the executor operations
`timescale 1ns/1ps
`default_nettype none
module slx_alu (
    input  wire logic [2:0] op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] reg_val,
    input  wire logic [7:0] literal,
    output logic      [7:0] result,
    output logic            is_zero
);
    // one result path per operation; idle and store pass the accumulator
    assign result = (op == slx_pkg::SLX_OP_DEC_SKZ) ? reg_val - slx_pkg::ONE_BYTE :
                    (op == slx_pkg::SLX_OP_INC_SKZ) ? reg_val + slx_pkg::ONE_BYTE :
                    (op == slx_pkg::SLX_OP_OR_LIT)  ? (acc | literal) :
                    (op == slx_pkg::SLX_OP_LD_LIT)  ? literal :
                    (op == slx_pkg::SLX_OP_OR_REG)  ? (acc | reg_val) : acc;
    assign is_zero = (result == slx_pkg::ZERO_BYTE);
endmodule
`default_nettype wire

// [skip_and_logic_ops_exec_test.sv]
// self-checking bench for the skip and logic operation executor
`timescale 1ns/1ps
`default_nettype none
module skip_and_logic_ops_exec_test;
    logic       clk = 0, rstn = 0, cyc_en = 0, dest = 0, reg_we, zero_flag, skip_active;
    logic [2:0] op = 3'h0;
    logic [6:0] faddr = 7'h00, reg_addr;
    logic [7:0] literal = 8'h00, reg_rdata = 8'h00, reg_wdata, acc;
    int         err_total = 0, checks_done = 0, seed = 81, m_acc = 0, m_zf = 0, m_skip = 0;
    int         res, wr;
    int         mem [128];
    // free-running 100 MHz clock
    always #5 clk = ~clk;
    slx_exec dut (.clk(clk), .rstn(rstn), .cyc_en(cyc_en), .op(op), .dest(dest), .faddr(faddr),
        .literal(literal), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .acc(acc), .zero_flag(zero_flag), .skip_active(skip_active));
    // compare helpers, counted and reported at once
    task automatic chk_byte(input logic [7:0] got, input int exp);
        checks_done++;
        if (got !== 8'(exp)) begin
            err_total++;
            $display("unexpected byte at %0t: got %h want %h", $time, got, 8'(exp));
        end
    endtask
    task automatic chk_bit(input logic got, input int exp);
        checks_done++;
        if (got !== 1'(exp)) begin
            err_total++;
            $display("unexpected flag at %0t: got %b want %b", $time, got, 1'(exp));
        end
    endtask
    // one instruction slot; registered state is checked first, as left by earlier slots
    task automatic step(input logic en, input logic [2:0] o, input logic d,
                        input logic [6:0] fa, input logic [7:0] lit);
        @(posedge clk);
        cyc_en <= en; op <= o; dest <= d; faddr <= fa; literal <= lit; reg_rdata <= mem[fa][7:0];
        @(negedge clk);
        chk_byte(acc, m_acc);
        chk_bit(zero_flag, m_zf);
        chk_bit(skip_active, m_skip);
        chk_byte({1'b0, reg_addr}, fa);
        wr = 0;
        if (en && m_skip != 0) m_skip = 0;
        else if (en) begin
            case (o)
                slx_pkg::SLX_OP_DEC_SKZ: res = (mem[fa] + 255) % 256;
                slx_pkg::SLX_OP_INC_SKZ: res = (mem[fa] + 1) % 256;
                slx_pkg::SLX_OP_OR_LIT:  res = m_acc | lit;
                slx_pkg::SLX_OP_OR_REG:  res = m_acc | mem[fa];
                slx_pkg::SLX_OP_ST_ACC:  res = m_acc;
                default:                 res = lit;
            endcase
            wr = (o == slx_pkg::SLX_OP_ST_ACC) || (d && o inside {slx_pkg::SLX_OP_DEC_SKZ,
                 slx_pkg::SLX_OP_INC_SKZ, slx_pkg::SLX_OP_OR_REG});
            if (o inside {slx_pkg::SLX_OP_OR_LIT, slx_pkg::SLX_OP_OR_REG}) m_zf = (res == 0);
            if (o inside {slx_pkg::SLX_OP_DEC_SKZ, slx_pkg::SLX_OP_INC_SKZ}) m_skip = (res == 0);
            if (o != slx_pkg::SLX_OP_IDLE && wr == 0) m_acc = res;
        end
        chk_bit(reg_we, wr);
        if (wr != 0) begin
            chk_byte(reg_wdata, res);
            mem[fa] = res;
        end
    endtask
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // directed corner cases, then random back-to-back slots
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = {$random(seed)} % 256;
        mem[5] = 1;
        mem[127] = 255;
        mem[9] = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        step(1'h1, slx_pkg::SLX_OP_LD_LIT, 1'h0, 7'h00, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_OR_LIT, 1'h0, 7'h00, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_OR_REG, 1'h1, 7'h09, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_OR_LIT, 1'h0, 7'h00, 8'h80);
        step(1'h1, slx_pkg::SLX_OP_DEC_SKZ, 1'h1, 7'h05, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_ST_ACC, 1'h0, 7'h7F, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_INC_SKZ, 1'h0, 7'h7F, 8'h00);
        step(1'h0, slx_pkg::SLX_OP_LD_LIT, 1'h0, 7'h00, 8'hFF);
        step(1'h1, slx_pkg::SLX_OP_LD_LIT, 1'h0, 7'h00, 8'hFF);
        step(1'h1, slx_pkg::SLX_OP_ST_ACC, 1'h1, 7'h7F, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_ST_ACC, 1'h0, 7'h00, 8'h00);
        // reset while a skip is pending: all state clears, file contents stay
        step(1'h1, slx_pkg::SLX_OP_LD_LIT, 1'h0, 7'h00, 8'hFF);
        step(1'h1, slx_pkg::SLX_OP_ST_ACC, 1'h0, 7'h10, 8'h00);
        step(1'h1, slx_pkg::SLX_OP_INC_SKZ, 1'h1, 7'h10, 8'h00);
        @(posedge clk);
        rstn <= 1'h0;
        cyc_en <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        m_acc = 0;
        m_zf = 0;
        m_skip = 0;
        step(1'h1, slx_pkg::SLX_OP_INC_SKZ, 1'h0, 7'h10, 8'h00);
        repeat (400) step(({$random(seed)} % 4) != 0, 3'({$random(seed)} % 7), 1'($random(seed)),
                          7'($random(seed)), 8'($random(seed)));
        step(0, slx_pkg::SLX_OP_IDLE, 0, 0, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
